// ---- rioc_defs.svh ----
`ifndef RIOC_DEFS_SVH
`define RIOC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RIOC_OFS_CTRL        12'h000
`define RIOC_OFS_START       12'h004
`define RIOC_OFS_STATUS      12'h008
`define RIOC_OFS_INT_STATUS  12'h00C
`define RIOC_OFS_INT_MASK    12'h010
`define RIOC_OFS_VALUES      12'h014

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RIOC_CTRL_MODE_LSB   0
`define RIOC_CTRL_HIGH_BIT   2
`define RIOC_ST_INT_TRIP     0
`define RIOC_ST_GEN_TRIP     1
`define RIOC_ST_BLOCK        2
`define RIOC_ST_DOUBLE       3
`define RIOC_ST_PEAK_LSB     16
`define RIOC_IRQ_RISE        0
`define RIOC_IRQ_FALL        1

// ----------------------------------------------------------------
// Reset values and setting limits (percent of rated current), scale factors and peak window length
// ----------------------------------------------------------------
`define RIOC_START_RESET     12'h0C8
`define RIOC_START_MIN       12'h00A
`define RIOC_START_MAX       12'h3E8
`define RIOC_START_MAX_HIGH  12'hBB8
`define RIOC_PCT_SCALE       16'h0064
`define RIOC_RATED_CODE      16'h1000
`define RIOC_PEAK_TO_RMS     16'h00B5
`define RIOC_PEAK_SHIFT      8
`define RIOC_PEAK_WINDOW     8'h14

`endif

// ---- rioc_peak.sv ----
`timescale 1ns/100ps
`include "rioc_defs.svh"

// Peak selection over a fixed block of samples that restarts every window
module rioc_peak
  import rioc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        sample_valid_in,
  input  wire logic [15:0] sample_in,
  output logic             peak_valid_out,
  output logic [15:0]      residual_peak_value_out
);

  // ----------------------------------------------------------------
  // Magnitude and window bookkeeping
  // ----------------------------------------------------------------
  logic [15:0] magnitude;       // |sample|, saturated
  logic [15:0] win_max_q;       // Largest magnitude in this window
  logic [7:0]  win_cnt_q;       // Samples seen in this window
  logic        win_last;        // Final sample of the window

  // Two's complement magnitude; -32768 saturates to keep 16 bits
  always_comb begin
    if (sample_in[15]) begin
      magnitude = (sample_in == 16'h8000) ? 16'h7FFF : 16'(~sample_in + 16'h0001);
    end else begin
      magnitude = sample_in;
    end
  end

  assign win_last = (win_cnt_q == `RIOC_PEAK_WINDOW - 8'h01);

  // Window counter, restarts after one network period of samples
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      win_cnt_q <= 8'h00;
    end else if (sample_valid_in) begin
      win_cnt_q <= win_last ? 8'h00 : win_cnt_q + 8'h01;
    end
  end

  // Running maximum; the final sample of a window clears it to zero
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      win_max_q <= 16'h0000;
    end else if (sample_valid_in) begin
      if (win_last) begin
        win_max_q <= 16'h0000;
      end else if (magnitude > win_max_q) begin
        win_max_q <= magnitude;
      end
    end
  end

  // Peak output, never lower than the present sample so pickup is sub-cycle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      residual_peak_value_out <= 16'h0000;
      peak_valid_out          <= 1'b0;
    end else begin
      peak_valid_out <= sample_valid_in;
      if (sample_valid_in) begin
        residual_peak_value_out <= (magnitude > win_max_q) ? magnitude : win_max_q;
      end
    end
  end

endmodule : rioc_peak

// ---- rioc_pkg.sv ----
package rioc_pkg;

  // Operating mode, off disables all tripping
  typedef enum logic [1:0] {
    RIOC_MODE_OFF  = 2'h0,
    RIOC_MODE_PEAK = 2'h1,
    RIOC_MODE_FUND = 2'h2
  } rioc_mode_t;

  // Settings that travel together from the register file
  typedef struct packed {
    rioc_mode_t  mode;
    logic        high_range;
    logic [11:0] start_pct;
  } rioc_cfg_t;

  // One measured sample with its fundamental companion
  typedef struct packed {
    logic [15:0] residual;
    logic [15:0] fundamental;
  } rioc_meas_t;

  // Evaluation sequencer, one-hot
  typedef enum logic [2:0] {
    RIOC_ST_IDLE    = 3'b001,
    RIOC_ST_COMPARE = 3'b010,
    RIOC_ST_UPDATE  = 3'b100
  } rioc_state_t;

endpackage : rioc_pkg

// ---- rioc_residual_ioc.sv ----
`timescale 1ns/100ps
`include "rioc_defs.svh"

module rioc_residual_ioc
  import rioc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Measurement stream from the preprocessing stage
  input  wire logic        sample_valid_in,
  input  wire logic [15:0] sample_in,
  input  wire logic [15:0] fundamental_rms_value_in,
  // Binary status inputs from user logic
  input  wire logic        threshold_double_in,
  input  wire logic        function_block_in,
  // Decisions
  output logic             internal_trip_out,
  output logic             general_trip_out,
  output logic             irq_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rioc_cfg_t   cfg_q;           // Settings written by software
  rioc_meas_t  meas_q;          // Sample held for its evaluation
  rioc_state_t state_q;         // Evaluation sequencer
  rioc_state_t state_d;
  logic [15:0] peak_value;      // From the peak stage
  logic        peak_valid;      // Peak stage result is fresh
  logic [15:0] compared_q;      // Quantity chosen for comparison
  logic [31:0] lhs_q;           // Measured value times 100
  logic [31:0] rhs_q;           // Percent times rated code
  logic        above;           // Comparison result
  logic        internal_trip_q; // Non-latched internal trip
  logic        general_trip_q;  // Gated trip output
  logic [1:0]  int_status_q;    // Sticky events
  logic [1:0]  int_mask_q;      // Event enables
  logic [1:0]  events;          // Raw events this cycle
  logic        trip_next;       // Internal trip for the next cycle
  logic        apb_write;       // Access phase of a write
  logic        apb_read;        // Access phase of a read
  logic        addr_hit;        // Address decodes to a register
  logic [11:0] start_limit;     // Upper bound of the setting
  logic [11:0] start_clamped;   // Written setting inside its range
  logic [15:0] peak_rms_eq;     // Peak scaled to an RMS equivalent
  logic [31:0] peak_product;    // Peak times scale factor

  // ----------------------------------------------------------------
  // Peak selection
  // ----------------------------------------------------------------
  rioc_peak u_peak (
    .clock_in                (clock_in),
    .rst_in                  (rst_in),
    .sample_valid_in         (sample_valid_in),
    .sample_in               (sample_in),
    .peak_valid_out          (peak_valid),
    .residual_peak_value_out (peak_value)
  );

  // Fundamental value is taken as it comes with the sample
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      meas_q <= '0;
    end else if (sample_valid_in) begin
      meas_q.residual    <= sample_in;
      meas_q.fundamental <= fundamental_rms_value_in;
    end
  end

  // ----------------------------------------------------------------
  // Evaluation sequencer
  // ----------------------------------------------------------------
  // One pass per sample; a new sample can only arrive every second
  // cycle or later without being merged into the running pass
  always_comb begin
    case (state_q)
      RIOC_ST_IDLE:    state_d = peak_valid ? RIOC_ST_COMPARE : RIOC_ST_IDLE;
      RIOC_ST_COMPARE: state_d = RIOC_ST_UPDATE;
      RIOC_ST_UPDATE:  state_d = peak_valid ? RIOC_ST_COMPARE : RIOC_ST_IDLE;
      default:         state_d = RIOC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= RIOC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Instantaneous decision
  // ----------------------------------------------------------------
  // Peak of a sine is 1.414 times its RMS, so scale by 181/256 to
  // keep one setting meaningful in both modes
  assign peak_product = 32'(peak_value) * 32'(`RIOC_PEAK_TO_RMS);
  assign peak_rms_eq  = peak_product[`RIOC_PEAK_SHIFT +: 16];

  // Select quantity when the fresh peak arrives
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      compared_q <= 16'h0000;
    end else if (peak_valid) begin
      if (cfg_q.mode == RIOC_MODE_FUND) begin
        compared_q <= meas_q.fundamental;
      end else begin
        compared_q <= peak_rms_eq;
      end
    end
  end

  // Percent compare without a divider: value*100 against pct*rated
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      lhs_q <= 32'h0000_0000;
      rhs_q <= 32'h0000_0000;
    end else if (state_q == RIOC_ST_COMPARE) begin
      lhs_q <= 32'(compared_q) * 32'(`RIOC_PCT_SCALE);
      if (threshold_double_in) begin
        rhs_q <= (32'(cfg_q.start_pct) * 32'(`RIOC_RATED_CODE)) << 1;
      end else begin
        rhs_q <= 32'(cfg_q.start_pct) * 32'(`RIOC_RATED_CODE);
      end
    end
  end

  assign above = (lhs_q > rhs_q);

  // Internal trip follows the comparison, no timer and no latch
  always_comb begin
    trip_next = internal_trip_q;
    if (cfg_q.mode == RIOC_MODE_OFF) begin
      trip_next = 1'b0;
    end else if (state_q == RIOC_ST_UPDATE) begin
      trip_next = above;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      internal_trip_q <= 1'b0;
    end else begin
      internal_trip_q <= trip_next;
    end
  end

  // ----------------------------------------------------------------
  // Decision logic
  // ----------------------------------------------------------------
  // Block acts at once, it does not wait for the next sample
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      general_trip_q <= 1'b0;
    end else begin
      general_trip_q <= trip_next && !function_block_in;
    end
  end

  assign internal_trip_out = internal_trip_q;
  assign general_trip_out  = general_trip_q;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Rising and falling edges of the general trip
  assign events[`RIOC_IRQ_RISE] = !general_trip_q && (trip_next && !function_block_in);
  assign events[`RIOC_IRQ_FALL] = general_trip_q && !(trip_next && !function_block_in);

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      int_status_q <= 2'h0;
    end else begin
      if (apb_write && paddr == `RIOC_OFS_INT_STATUS) begin
        int_status_q <= (int_status_q & ~pwdata[1:0]) | events;
      end else begin
        int_status_q <= int_status_q | events;
      end
    end
  end

  assign irq_out = |(int_status_q & int_mask_q);

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  // Zero wait state; unmapped addresses answer with pslverr
  assign apb_write = psel && penable && pwrite;
  assign apb_read  = psel && penable && !pwrite;
  assign pready    = 1'b1;

  always_comb begin
    case (paddr)
      `RIOC_OFS_CTRL,
      `RIOC_OFS_START,
      `RIOC_OFS_STATUS,
      `RIOC_OFS_INT_STATUS,
      `RIOC_OFS_INT_MASK,
      `RIOC_OFS_VALUES: addr_hit = 1'b1;
      default:          addr_hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_hit;

  // Range of the setting depends on the high-range option
  assign start_limit = cfg_q.high_range ? `RIOC_START_MAX_HIGH : `RIOC_START_MAX;

  // Out-of-range writes saturate rather than being refused
  always_comb begin
    if (pwdata[11:0] < `RIOC_START_MIN) begin
      start_clamped = `RIOC_START_MIN;
    end else if (pwdata[31:12] != 20'h00000 || pwdata[11:0] > start_limit) begin
      start_clamped = start_limit;
    end else begin
      start_clamped = pwdata[11:0];
    end
  end

  // Settings; mode code 3 is not a mode and is stored as off
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_q.mode       <= RIOC_MODE_OFF;
      cfg_q.high_range <= 1'b0;
      cfg_q.start_pct  <= `RIOC_START_RESET;
    end else if (apb_write) begin
      if (paddr == `RIOC_OFS_CTRL) begin
        case (pwdata[`RIOC_CTRL_MODE_LSB +: 2])
          2'h1:    cfg_q.mode <= RIOC_MODE_PEAK;
          2'h2:    cfg_q.mode <= RIOC_MODE_FUND;
          default: cfg_q.mode <= RIOC_MODE_OFF;
        endcase
        cfg_q.high_range <= pwdata[`RIOC_CTRL_HIGH_BIT];
        // Dropping the option pulls an extended setting back in range
        if (!pwdata[`RIOC_CTRL_HIGH_BIT] && cfg_q.start_pct > `RIOC_START_MAX) begin
          cfg_q.start_pct <= `RIOC_START_MAX;
        end
      end else if (paddr == `RIOC_OFS_START) begin
        cfg_q.start_pct <= start_clamped;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      int_mask_q <= 2'h0;
    end else if (apb_write && paddr == `RIOC_OFS_INT_MASK) begin
      int_mask_q <= pwdata[1:0];
    end
  end

  // Read data registered-free: mux of live state, zero when idle
  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_read) begin
      case (paddr)
        `RIOC_OFS_CTRL: begin
          prdata[`RIOC_CTRL_MODE_LSB +: 2] = cfg_q.mode;
          prdata[`RIOC_CTRL_HIGH_BIT]      = cfg_q.high_range;
        end
        `RIOC_OFS_START: begin
          prdata[11:0] = cfg_q.start_pct;
        end
        `RIOC_OFS_STATUS: begin
          prdata[`RIOC_ST_INT_TRIP]       = internal_trip_q;
          prdata[`RIOC_ST_GEN_TRIP]       = general_trip_q;
          prdata[`RIOC_ST_BLOCK]          = function_block_in;
          prdata[`RIOC_ST_DOUBLE]         = threshold_double_in;
          prdata[`RIOC_ST_PEAK_LSB +: 16] = peak_value;
        end
        `RIOC_OFS_INT_STATUS: begin
          prdata[1:0] = int_status_q;
        end
        `RIOC_OFS_INT_MASK: begin
          prdata[1:0] = int_mask_q;
        end
        `RIOC_OFS_VALUES: begin
          prdata[15:0]  = compared_q;
          prdata[31:16] = meas_q.fundamental;
        end
        default: begin
          prdata = 32'h0000_0000;
        end
      endcase
    end
  end

endmodule : rioc_residual_ioc

// ---- rioc_residual_ioc_sva.sv ----
`timescale 1ns/100ps
module rioc_residual_ioc_sva
  import rioc_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sample_valid_in,
  input wire logic        function_block_in,
  input wire logic        internal_trip_out,
  input wire logic        general_trip_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Control write, the only other way a trip may drop
  wire ctrl_wr = psel && penable && pwrite && (paddr == 12'h000);

  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------
  // Decision checks
  // ----------------------------------------
  a_gen_needs_int: assert property (general_trip_out |-> internal_trip_out)
    else $error("general trip without internal trip");
  a_block_kills_gen: assert property (function_block_in |=> !general_trip_out)
    else $error("general trip while blocked");
  a_gen_follows_int: assert property (internal_trip_out && !function_block_in ##1 internal_trip_out
    |-> general_trip_out)
    else $error("general trip missing");
  a_rise_needs_sample: assert property ($rose(internal_trip_out) |-> $past(sample_valid_in, 4))
    else $error("trip rose off the sample timing");
  a_fall_has_cause: assert property ($fell(internal_trip_out)
    |-> $past(sample_valid_in, 4) || $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("trip fell with no evaluation");
  a_reset_clears: assert property ($fell(rst_in) |-> !internal_trip_out && !general_trip_out)
    else $error("trips not cleared by reset");
  // Bus answers, zero wait states
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  a_unmapped_err: assert property (psel && penable && (paddr > 12'h014) |-> pslverr)
    else $error("no error on unmapped address");
endmodule : rioc_residual_ioc_sva

bind rioc_residual_ioc rioc_residual_ioc_sva i_sva (.clock_in(clock_in), .rst_in(rst_in), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .sample_valid_in(sample_valid_in), .function_block_in(function_block_in),
  .internal_trip_out(internal_trip_out), .general_trip_out(general_trip_out));

// ---- rioc_residual_ioc_tb.sv ----
`timescale 1ns/100ps
`include "rioc_defs.svh"
module rioc_residual_ioc_tb;
  import rioc_pkg::*;
  logic        clock_in, rst_in, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sample_valid_in, dbl, blk, irq_out, internal_trip_out, general_trip_out, go;
  logic [15:0] sample_in, fund_rms, amp, fund_set;
  logic [1:0]  gap;
  int          fails, n_tests, cycles, mode_now, start_now;
  int          tf[6] = '{8193, 8192, 16384, 16385, 16385, 8193}; // Fundamental steps
  logic        td[6] = '{0, 0, 1, 1, 1, 0};                      // Doubling
  logic        tk[6] = '{0, 0, 0, 0, 1, 0};                      // Blocking

  rioc_residual_ioc i_dut (.clock_in(clock_in), .rst_in(rst_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid_in(sample_valid_in), .sample_in(sample_in), .fundamental_rms_value_in(fund_rms),
    .threshold_double_in(dbl), .function_block_in(blk), .internal_trip_out(internal_trip_out),
    .general_trip_out(general_trip_out), .irq_out(irq_out));
  rioc_source_model i_src (.clock_in(clock_in), .rst_in(rst_in), .go_in(go), .amp_in(amp),
    .fund_in(fund_set), .gap_in(gap), .sample_valid_out(sample_valid_in), .sample_out(sample_in),
    .fundamental_out(fund_rms));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // Whole run needs some 2300 cycles
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32
  // One APB transfer, read data kept in rd and err
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Strict compare against start, doubled on request; peak scaled to RMS
  function automatic logic exp_trip(input int m, input int a, input int f, input int s, input logic d);
    int q;
    q = (m == 1) ? (a * 181) / 256 : f;
    return (m == 1 || m == 2) && (q * 100 > s * 4096 * (d ? 2 : 1));
  endfunction : exp_trip
  // Steady stimulus long enough to flush two peak windows
  task automatic run(input int a, input int f, input logic d, input logic b);
    logic e;
    amp <= a[15:0]; fund_set <= f[15:0]; dbl <= d; blk <= b; go <= 1'b1;
    repeat (45) begin
      do @(posedge clock_in); while (sample_valid_in !== 1'b1);
    end
    repeat (6) @(posedge clock_in);
    e = exp_trip(mode_now, a, f, start_now, d);
    chk1(internal_trip_out, e);
    chk1(general_trip_out, e & ~b);
  endtask : run

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dbl = 1'b0;
    blk = 1'b0;
    go = 1'b0;
    amp = 16'h0;
    fund_set = 16'h0;
    gap = 2'h0;
    mode_now = 0;
    start_now = 200;
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    chk1(internal_trip_out, 1'b0);
    chk1(general_trip_out, 1'b0);
    apb(1'b0, `RIOC_OFS_CTRL, 32'h0);
    chk32(rd, 32'h0);
    apb(1'b0, `RIOC_OFS_START, 32'h0);
    chk32(rd, 32'h0C8);
    apb(1'b0, 12'h020, 32'h0);
    chk1(err, 1'b1);
    run(20000, 60000, 1'b0, 1'b0);
    apb(1'b1, `RIOC_OFS_CTRL, 32'h2);
    mode_now = 2;
    for (int i = 0; i < 6; i++) begin
      run(0, tf[i], td[i], tk[i]);
    end
    apb(1'b0, `RIOC_OFS_VALUES, 32'h0);
    chk32(rd, 32'h2001_2001);
    apb(1'b1, `RIOC_OFS_CTRL, 32'h1);
    mode_now = 1;
    gap <= 2'h3;
    run(11588, 0, 1'b0, 1'b0);
    apb(1'b0, `RIOC_OFS_STATUS, 32'h0);
    chk32(rd, 32'h2D44_0003);
    run(11587, 0, 1'b0, 1'b0);
    gap <= 2'h0;
    apb(1'b1, `RIOC_OFS_CTRL, 32'h3);
    apb(1'b0, `RIOC_OFS_CTRL, 32'h0);
    chk32(rd, 32'h0);
    mode_now = 0;
    run(0, 9000, 1'b0, 1'b0);
    // Status shows both binary inputs while nothing can trip
    dbl <= 1'b1;
    blk <= 1'b1;
    apb(1'b0, `RIOC_OFS_STATUS, 32'h0);
    chk32(rd, 32'h0000_000C);
    dbl <= 1'b0;
    blk <= 1'b0;
    apb(1'b1, `RIOC_OFS_START, 32'h5);
    apb(1'b0, `RIOC_OFS_START, 32'h0);
    chk32(rd, 32'h00A);
    apb(1'b1, `RIOC_OFS_START, 32'h7D0);
    apb(1'b0, `RIOC_OFS_START, 32'h0);
    chk32(rd, 32'h3E8);
    apb(1'b1, `RIOC_OFS_CTRL, 32'h4);
    apb(1'b1, `RIOC_OFS_START, 32'hFA0);
    apb(1'b0, `RIOC_OFS_START, 32'h0);
    chk32(rd, 32'hBB8);
    apb(1'b1, `RIOC_OFS_CTRL, 32'h0);
    apb(1'b0, `RIOC_OFS_START, 32'h0);
    chk32(rd, 32'h3E8);
    apb(1'b1, `RIOC_OFS_START, 32'h00A);
    apb(1'b1, `RIOC_OFS_CTRL, 32'h2);
    mode_now = 2;
    start_now = 10;
    run(0, 410, 1'b0, 1'b0);
    run(0, 409, 1'b0, 1'b0);
    // Interrupt: raise, clear, then a masked event
    apb(1'b1, `RIOC_OFS_START, 32'h0C8);
    start_now = 200;
    apb(1'b1, `RIOC_OFS_INT_STATUS, 32'h3);
    apb(1'b1, `RIOC_OFS_INT_MASK, 32'h1);
    run(0, 9000, 1'b0, 1'b0);
    chk1(irq_out, 1'b1);
    apb(1'b0, `RIOC_OFS_INT_STATUS, 32'h0);
    chk32(rd, 32'h1);
    apb(1'b1, `RIOC_OFS_INT_STATUS, 32'h1);
    @(posedge clock_in);
    chk1(irq_out, 1'b0);
    apb(1'b1, `RIOC_OFS_INT_MASK, 32'h0);
    run(0, 0, 1'b0, 1'b0);
    chk1(irq_out, 1'b0);
    apb(1'b0, `RIOC_OFS_INT_STATUS, 32'h0);
    chk32(rd, 32'h2);
    report_and_stop();
  end
endmodule : rioc_residual_ioc_tb

// ---- rioc_source_model.sv ----
`timescale 1ns/100ps
// Preprocessing stage: alternating samples plus fundamental RMS
module rioc_source_model (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        go_in,
  input  wire logic [15:0] amp_in,
  input  wire logic [15:0] fund_in,
  input  wire logic [1:0]  gap_in,
  output logic             sample_valid_out,
  output logic [15:0]      sample_out,
  output logic [15:0]      fundamental_out
);
  logic [3:0] cnt_q;  // Cycles until next sample
  logic       sign_q; // Polarity of next sample

  // Sample pacing, never closer than three cycles
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q            <= 4'h0;
      sign_q           <= 1'b0;
      sample_valid_out <= 1'b0;
      sample_out       <= 16'h0000;
      fundamental_out  <= 16'h0000;
    end else begin
      sample_valid_out <= 1'b0;
      // Outside a sample the lines toggle, so no stale value looks valid
      sample_out       <= ~sample_out;
      fundamental_out  <= ~fundamental_out;
      if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (go_in) begin
        sample_valid_out <= 1'b1;
        sign_q           <= ~sign_q;
        sample_out       <= sign_q ? 16'h0000 - amp_in : amp_in;
        fundamental_out  <= fund_in;
        cnt_q            <= 4'h2 + {2'h0, gap_in};
      end
    end
  end
endmodule : rioc_source_model
